/* File: cmp_ctrl_pkg.sv */
// Constants shared by the comparator control logic
package cmp_ctrl_pkg;
  localparam logic [7:0] ADC_CTRL_STATUS_B_OFFS = 8'h00;
  localparam logic [7:0] CMP_CTRL_STATUS_OFFS   = 8'h04;
  localparam logic [7:0] CONV_CTRL_OFFS         = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFS        = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFFS          = 8'h10;
  localparam int CMP_DISABLE_BIT  = 7;
  localparam int BANDGAP_SEL_BIT  = 6;
  localparam int CMP_OUTPUT_BIT   = 5;
  localparam int EVENT_FLAG_BIT   = 4;
  localparam int IRQ_EN_BIT       = 3;
  localparam int CAPTURE_ROUTE_BIT = 2;
  localparam int MUX_EN_BIT       = 6;
  localparam int CONV_EN_BIT      = 0;
  localparam int PWR_RED_BIT      = 1;
  localparam int GLOBAL_IE_BIT    = 2;
  localparam logic [7:0] ADC_B_RESET   = 8'h00;
  localparam logic [7:0] ADC_B_WMASK   = 8'h47;
  localparam logic [7:0] CMP_CS_RESET  = 8'h00;
  localparam logic [1:0] MODE_TOGGLE   = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALL     = 2'h2;
  localparam logic [1:0] MODE_RISE     = 2'h3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage : cmp_ctrl_pkg

/* File: comparator_control_logic.sv */
// Comparator control: synchroniser, input selection, event flag, AXI4-Lite registers
//
// Behaviour
// - Comparator result is synchronised, visible one to two clocks later.
// - Disable bit powers the comparator down, effective at any time.
// - Bandgap select picks internal reference, else positive pin, as positive input.
// - Flag set when synchronised output change matches chosen event mode.
// - Comparator interrupt requested only with flag, enable and global enable all set.
// - Flag cleared automatically on interrupt vector entry.
// - Writing one clears flag; zero leaves it.
// - Capture route enable connects output to timer capture trigger.
// - Routed output goes through timer's noise canceler and edge select.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Negative pin used unless mux enabled and converter off; else channel 0-7.
// - Converter multiplexer works only while power reduction bit is zero.
// - Converter enable gives multiplexer to converter, not comparator.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module comparator_control_logic
  import cmp_ctrl_pkg::*;
#(
  parameter int CHANNELS = 8
)(
  input  wire logic        aclk,            // System clock, 250 MHz
  input  wire logic        aresetn,         // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [7:0]  s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic        comparator_raw,  // Raw analog comparator result
  input  wire logic        vector_entry,    // Pulse: processor enters comparator vector
  input  wire logic [2:0]  channel_select,  // Converter mux channel code
  output logic             comparator_power_down, // Power off the comparator
  output logic             positive_sel_bandgap,  // 1: bandgap on positive input
  output logic             negative_sel_channel,  // 1: mux channel on negative input
  output logic [CHANNELS-1:0] negative_channel_onehot, // Selected channel
  output logic             capture_trigger, // To timer capture front end
  output logic             comparator_irq,  // Interrupt request to the processor
  output logic             irq              // Masked sticky-status interrupt
);

  // Channel code is three bits wide, so only eight channels can be addressed
  generate
    if (CHANNELS != 8)
    begin : g_bad_channels
      $error("CHANNELS must be 8");
    end
  endgenerate

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [7:0] adcb;
    logic [7:0] cs;
    logic [2:0] ctrl;
    logic [1:0] ists;
    logic [1:0] imask;
    logic       aw_got;
    logic [7:0] aw_addr;
    logic       w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic rise_ev;
  logic fall_ev;
  logic evt;
  logic wr_go;
  logic ch_live;

  always_comb
  begin
    state_next = state_reg;
    rise_ev = state_reg.sync2 & ~state_reg.prev;
    fall_ev = ~state_reg.sync2 & state_reg.prev;
    unique case (state_reg.cs[1:0])
      MODE_TOGGLE:   evt = rise_ev | fall_ev;
      MODE_RESERVED: evt = 1'b0;
      MODE_FALL:     evt = fall_ev;
      MODE_RISE:     evt = rise_ev;
    endcase
    // First stage feeds only the second
    state_next.sync1 = comparator_raw;
    state_next.sync2 = state_reg.sync1;
    state_next.prev  = state_reg.sync2;

    if (!state_reg.aw_got && s_axi_awvalid)
    begin
      state_next.aw_got  = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (!state_reg.w_got && s_axi_wvalid)
    begin
      state_next.w_got  = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    wr_go = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
    if (wr_go)
    begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = RESP_OKAY;
      if (state_reg.w_strb[0])
      begin
        unique case (state_reg.aw_addr)
          ADC_CTRL_STATUS_B_OFFS:
            state_next.adcb = state_reg.w_data[7:0] & ADC_B_WMASK;
          CMP_CTRL_STATUS_OFFS:
          begin
            state_next.cs[7:6] = state_reg.w_data[7:6];
            state_next.cs[3:0] = state_reg.w_data[3:0];
            if (state_reg.w_data[EVENT_FLAG_BIT])
              state_next.cs[EVENT_FLAG_BIT] = 1'b0;
          end
          CONV_CTRL_OFFS:
            state_next.ctrl = state_reg.w_data[2:0];
          IRQ_STATUS_OFFS:
            state_next.ists = state_reg.ists & ~state_reg.w_data[1:0];
          IRQ_MASK_OFFS:
            state_next.imask = state_reg.w_data[1:0];
          default:
            state_next.bresp = RESP_SLVERR;
        endcase
      end
      else if (!(state_reg.aw_addr inside {ADC_CTRL_STATUS_B_OFFS, CMP_CTRL_STATUS_OFFS,
                 CONV_CTRL_OFFS, IRQ_STATUS_OFFS, IRQ_MASK_OFFS}))
        state_next.bresp = RESP_SLVERR;
    end
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;
    if (vector_entry)
      state_next.cs[EVENT_FLAG_BIT] = 1'b0;
    // Hardware set wins over any clear in the same cycle
    if (evt)
    begin
      state_next.cs[EVENT_FLAG_BIT] = 1'b1;
      state_next.ists[0] = 1'b1;
    end
    if (state_reg.sync2 != state_reg.prev)
      state_next.ists[1] = 1'b1;

    if (!state_reg.rvalid && s_axi_arvalid)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = RESP_OKAY;
      state_next.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADC_CTRL_STATUS_B_OFFS: state_next.rdata[7:0] = state_reg.adcb;
        // Output bit comes straight off the second stage to keep the lag at one to two clocks
        CMP_CTRL_STATUS_OFFS:   state_next.rdata[7:0] = {state_reg.cs[CMP_DISABLE_BIT:BANDGAP_SEL_BIT],
                                  state_reg.sync2, state_reg.cs[EVENT_FLAG_BIT:0]};
        CONV_CTRL_OFFS:         state_next.rdata[2:0] = state_reg.ctrl;
        IRQ_STATUS_OFFS:        state_next.rdata[1:0] = state_reg.ists;
        IRQ_MASK_OFFS:          state_next.rdata[1:0] = state_reg.imask;
        default:                state_next.rresp = RESP_SLVERR;
      endcase
    end
    else if (state_reg.rvalid && s_axi_rready)
      state_next.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg       <= '0;
      state_reg.adcb  <= ADC_B_RESET;
      state_reg.cs    <= CMP_CS_RESET;
    end
    else
      state_reg <= state_next;
  end

  assign s_axi_awready = !state_reg.aw_got;
  assign s_axi_wready  = !state_reg.w_got;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;

  assign comparator_power_down = state_reg.cs[CMP_DISABLE_BIT];
  assign positive_sel_bandgap  = state_reg.cs[BANDGAP_SEL_BIT];
  // Mux needs converter off and its power reduction clear
  assign ch_live = state_reg.adcb[MUX_EN_BIT] & ~state_reg.ctrl[CONV_EN_BIT]
                 & ~state_reg.ctrl[PWR_RED_BIT];
  assign negative_sel_channel = ch_live;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_chan
      assign negative_channel_onehot[g] = ch_live && (channel_select == 3'(g));
    end
  endgenerate

  // Timer's own front end filters it, so no extra filtering here
  assign capture_trigger = state_reg.cs[CAPTURE_ROUTE_BIT] & state_reg.sync2;
  assign comparator_irq  = state_reg.cs[EVENT_FLAG_BIT] & state_reg.cs[IRQ_EN_BIT]
                         & state_reg.ctrl[GLOBAL_IE_BIT];
  assign irq = |(state_reg.ists & state_reg.imask);

  // Steps of the flag behaviour, shared by the properties below
  sequence seq_cs_write;
    wr_go && state_reg.w_strb[0] && state_reg.aw_addr == CMP_CTRL_STATUS_OFFS;
  endsequence
  sequence seq_quiet_cycle;
    !evt && !vector_entry;
  endsequence
  sequence seq_flag_held;
    state_reg.cs[EVENT_FLAG_BIT] && !state_reg.w_data[EVENT_FLAG_BIT] && !vector_entry;
  endsequence
  sequence seq_rise_seen;
    state_reg.cs[1:0] == MODE_RISE && rise_ev;
  endsequence
  sequence seq_fall_seen;
    state_reg.cs[1:0] == MODE_FALL && fall_ev;
  endsequence
  sequence seq_toggle_seen;
    state_reg.cs[1:0] == MODE_TOGGLE && (rise_ev || fall_ev);
  endsequence

  chk_sync_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg.sync1 |=> state_reg.sync2)
    else $error("sync stage lost");
  chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    comparator_irq |-> state_reg.cs[IRQ_EN_BIT] && state_reg.ctrl[GLOBAL_IE_BIT])
    else $error("irq without enable");
  chk_rise_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_rise_seen |=> state_reg.cs[EVENT_FLAG_BIT])
    else $error("rise event missed");
  chk_reserved_none: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg.cs[1:0] == MODE_RESERVED && !state_reg.cs[EVENT_FLAG_BIT] && !wr_go)
      |=> !state_reg.cs[EVENT_FLAG_BIT])
    else $error("reserved mode set flag");
  chk_vector_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (vector_entry && !evt) |=> !state_reg.cs[EVENT_FLAG_BIT])
    else $error("vector did not clear flag");
  chk_mux_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg.ctrl[CONV_EN_BIT] |-> !negative_sel_channel)
    else $error("mux used while converter on");
  chk_capture_route: assert property (@(posedge aclk) disable iff (!aresetn)
    !state_reg.cs[CAPTURE_ROUTE_BIT] |-> !capture_trigger)
    else $error("capture routed while off");
  chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("bvalid dropped");
  chk_fall_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_fall_seen |=> state_reg.cs[EVENT_FLAG_BIT])
    else $error("fall event missed");
  chk_toggle_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_toggle_seen |=> state_reg.cs[EVENT_FLAG_BIT])
    else $error("toggle event missed");
  chk_flag_w1c: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_cs_write ##0 seq_quiet_cycle ##0 state_reg.w_data[EVENT_FLAG_BIT]
      |=> !state_reg.cs[EVENT_FLAG_BIT])
    else $error("write one did not clear flag");
  chk_flag_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_cs_write ##0 seq_flag_held |=> state_reg.cs[EVENT_FLAG_BIT])
    else $error("write zero cleared flag");
  chk_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg.cs[EVENT_FLAG_BIT] && state_reg.cs[IRQ_EN_BIT] && state_reg.ctrl[GLOBAL_IE_BIT])
      |-> comparator_irq)
    else $error("irq not requested");
  chk_power_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_cs_write |=> comparator_power_down == $past(state_reg.w_data[CMP_DISABLE_BIT]))
    else $error("disable write not applied");
  chk_bandgap_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_cs_write |=> positive_sel_bandgap == $past(state_reg.w_data[BANDGAP_SEL_BIT]))
    else $error("bandgap write not applied");
  chk_channel_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
    negative_sel_channel |-> $onehot(negative_channel_onehot)
      && negative_channel_onehot[channel_select])
    else $error("channel select wrong");
  chk_channel_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !negative_sel_channel |-> negative_channel_onehot == '0)
    else $error("channel selected while pin in use");
  chk_pwr_red_block: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg.ctrl[PWR_RED_BIT] |-> !negative_sel_channel)
    else $error("mux used while powered down");
  chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");

endmodule : comparator_control_logic

/* File: cmp_src_model.sv */
// Behavioural analog comparator that produces the raw result level
`timescale 1ns/1ns
module cmp_src_model (
  input  wire logic level_req,      // Analog difference sign wanted by the bench
  input  wire logic power_down,     // Comparator power switch from the block
  output logic      comparator_raw  // Raw asynchronous comparator result
);
  // An unpowered comparator drops low; the 1 ns lag keeps edges off the clock edge
  always @(level_req or power_down)
    comparator_raw <= #1 (level_req & ~power_down);
endmodule : cmp_src_model

/* File: test_comparator_control_logic.sv */
// Self-checking bench for the comparator control logic
`timescale 1ns/1ns
module test_comparator_control_logic;
  import cmp_ctrl_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, vec, lvl;
  logic        awready, wready, bvalid, arready, rvalid, raw, pd, bg, nsel, cap, cirq, irq;
  logic [7:0]  awaddr, araddr, oh;
  logic [31:0] wdata, rdata, seed, rv;
  logic [3:0]  wstrb;
  logic [2:0]  chs;
  logic [1:0]  bresp, rresp, bresp_seen;
  int          n_fail, n_compared, cyc;

  comparator_control_logic i_comparator_control_logic (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comparator_raw(raw), .vector_entry(vec), .channel_select(chs),
    .comparator_power_down(pd), .positive_sel_bandgap(bg), .negative_sel_channel(nsel),
    .negative_channel_onehot(oh), .capture_trigger(cap), .comparator_irq(cirq), .irq(irq));
  cmp_src_model i_cmp_src_model (.level_req(lvl), .power_down(pd), .comparator_raw(raw));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic ev(input logic [1:0] m, input logic rise);
    return (m == MODE_TOGGLE) | ((m == MODE_FALL) & ~rise) | ((m == MODE_RISE) & rise);
  endfunction : ev

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // Each channel is dropped at the edge that takes it; answers are taken at that same edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_open;
    logic w_open;
    logic done;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_open = 1'b1;
    w_open  = 1'b1;
    done    = 1'b0;
    while (!done)
    begin
      @(posedge aclk);
      if (aw_open && awready)
      begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready)
      begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid)
      begin
        done       = 1'b1;
        bresp_seen = bresp;
        bready     <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_open;
    logic done;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    ar_open = 1'b1;
    done    = 1'b0;
    while (!done)
    begin
      @(posedge aclk);
      if (ar_open && arready)
      begin
        ar_open = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid)
      begin
        done   = 1'b1;
        d      = rdata;
        r      = rresp;
        rready <= 1'b0;
      end
    end
  endtask : rd

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_fail++;
      close_out();
    end
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    seed    = 55;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    vec     = 1'b0;
    lvl     = 1'b0;
    chs     = 3'h0;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    wdata   = 32'h0;
    wstrb   = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADC_CTRL_STATUS_B_OFFS, d, r);
    chk(d, {24'h0, ADC_B_RESET});
    rd(CMP_CTRL_STATUS_OFFS, d, r);
    chk(d, {24'h0, CMP_CS_RESET});
    rd(8'h14, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h14, 32'hFF);
    chk({30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
    wr(ADC_CTRL_STATUS_B_OFFS, 32'hFF);
    chk({30'h0, bresp_seen}, {30'h0, RESP_OKAY});
    rd(ADC_CTRL_STATUS_B_OFFS, d, r);
    chk(d, {24'h0, ADC_B_WMASK});
    for (int i = 0; i < 8; i++)
    begin
      rv = xs();
      wr(CONV_CTRL_OFFS, {30'h0, rv[1:0]});
      chs <= i[2:0];
      @(negedge aclk);
      chk({nsel, oh}, {~|rv[1:0], (~|rv[1:0]) ? 8'h01 << i : 8'h00});
    end
    wr(CONV_CTRL_OFFS, 32'h4);
    @(negedge aclk);
    chk({nsel, oh}, {1'b1, 8'h01 << chs});
    wr(ADC_CTRL_STATUS_B_OFFS, 32'h07);
    @(negedge aclk);
    chk({nsel, oh}, 9'h000);
    wr(CMP_CTRL_STATUS_OFFS, 32'hC0);
    chk({pd, bg}, 2'h3);
    wr(CMP_CTRL_STATUS_OFFS, 32'h00);
    chk({pd, bg}, 2'h0);
    wr(IRQ_MASK_OFFS, 32'h1);
    for (int m = 0; m < 4; m++)
      for (int e = 0; e < 2; e++)
      begin
        wr(CMP_CTRL_STATUS_OFFS, 32'h10 | m);
        wr(IRQ_STATUS_OFFS, 32'h3);
        lvl <= ~lvl;
        repeat (5) @(posedge aclk);
        rd(CMP_CTRL_STATUS_OFFS, d, r);
        chk(d[5], lvl);
        chk({d[4], irq}, {2{ev(m[1:0], lvl)}});
      end
    wr(IRQ_STATUS_OFFS, 32'h3);
    chk(irq, 1'b0);
    wr(CMP_CTRL_STATUS_OFFS, 32'h10);
    wr(CMP_CTRL_STATUS_OFFS, 32'h1C);
    lvl <= ~lvl;
    repeat (5) @(posedge aclk);
    // Capture interrupt gating is the timer mask's job; only the routed level is seen here
    chk({cirq, cap}, {1'b1, lvl});
    wr(CMP_CTRL_STATUS_OFFS, 32'h0C);
    chk(cirq, 1'b1);
    wr(CONV_CTRL_OFFS, 32'h0);
    chk(cirq, 1'b0);
    wr(CONV_CTRL_OFFS, 32'h4);
    chk(cirq, 1'b1);
    vec <= 1'b1;
    @(posedge aclk);
    vec <= 1'b0;
    @(negedge aclk);
    chk(cirq, 1'b0);
    @(posedge aclk);
    lvl <= ~lvl;
    repeat (5) @(posedge aclk);
    chk(cirq, 1'b1);
    wr(CMP_CTRL_STATUS_OFFS, 32'h1C);
    chk({cirq, cap}, {1'b0, lvl});
    lvl <= ~lvl;
    repeat (5) @(posedge aclk);
    chk(cap, 1'b1);
    wr(CMP_CTRL_STATUS_OFFS, 32'h00);
    chk(cap, 1'b0);
    close_out();
  end
endmodule : test_comparator_control_logic
